/* rtl/gom_defs.vh */
// constants for the pin 2 output source multiplexer
`ifndef GOM_DEFS_VH
`define GOM_DEFS_VH

// ****************************************************************
// register map
// ****************************************************************
`define GOM_ADDR_W          12
`define GOM_CTL_INDEX       12'h012
`define GOM_CTL_ADDR        12'h048
`define GOM_STAT_ADDR       12'h100
`define GOM_CTL_RESET       8'h00

// ****************************************************************
// control field positions
// ****************************************************************
`define GOM_SEL_HI          7
`define GOM_SEL_LO          5
`define GOM_SRC_HI          4
`define GOM_SRC_LO          2
`define GOM_VAL_BIT         1
`define GOM_EN_BIT          0

// ****************************************************************
// source group codes
// ****************************************************************
`define GOM_SRC_RX0         3'h0
`define GOM_SRC_RX3         3'h3
`define GOM_SRC_DEV         3'h4
`define GOM_SRC_RSVD        3'h5
`define GOM_SRC_TX0         3'h6
`define GOM_SRC_TX1         3'h7

// ****************************************************************
// signal select codes
// ****************************************************************
`define GOM_RX_LOCK         3'h4
`define GOM_RX_PASS         3'h5
`define GOM_RX_FV           3'h6
`define GOM_RX_LV           3'h7
`define GOM_DEV_LOCAL       3'h0
`define GOM_DEV_ANY_LOCK    3'h1
`define GOM_DEV_ALL_PASS    3'h2
`define GOM_DEV_FSYNC       3'h4
`define GOM_TX_PASS_AND     3'h0
`define GOM_TX_PASS_OR      3'h1
`define GOM_TX_FV           3'h2
`define GOM_TX_LV           3'h3
`define GOM_TX_SYNC         3'h4
`define GOM_TX_IRQ          3'h5

// ****************************************************************
// status register bits
// ****************************************************************
`define GOM_ST_LEVEL        0
`define GOM_ST_DRIVE        1
`define GOM_ST_RAW          2
`define GOM_ST_RSVD         3
`define GOM_ST_ANY_LOCK     4
`define GOM_ST_ALL_PASS     5

`endif

/* rtl/gom_ctl_store.v */
// control register storage for the pin 2 output control byte
`timescale 1ns/100ps
`include "gom_defs.vh"

module gom_ctl_store (
	// clock and reset
	input  wire       clk,
	input  wire       reset,
	// write port
	input  wire       wr_en,
	input  wire [7:0] wr_data,
	// stored value
	output wire [7:0] ctl_q
);

	reg [7:0] ctl_ff;

	// ****************************************************************
	// storage
	// ****************************************************************
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ctl_ff <= `GOM_CTL_RESET;
		end else if (wr_en) begin
			ctl_ff <= wr_data;
		end
	end

	assign ctl_q = ctl_ff;

endmodule // gom_ctl_store

/* rtl/gom_src_mux.v */
// group and signal selection for the pin 2 output source
`timescale 1ns/100ps
`include "gom_defs.vh"

module gom_src_mux (
	// selection
	input  wire [2:0]  src,
	input  wire [2:0]  sel,
	// candidate signals, eight per group
	input  wire [31:0] rx_vec,
	input  wire [7:0]  dev_vec,
	input  wire [15:0] tx_vec,
	// result
	output reg         mux_out,
	output reg         rsvd_hit
);

	// reserved combinations per group, shared by both outputs
	function is_rsvd;
		input [2:0] f_src;
		input [2:0] f_sel;
		begin
			if (f_src == `GOM_SRC_RSVD) begin
				is_rsvd = 1'b1;
			end else if (f_src == `GOM_SRC_DEV) begin
				is_rsvd = (f_sel == 3'h3) || (f_sel > `GOM_DEV_FSYNC);
			end else if (f_src[2:1] == 2'b11) begin
				is_rsvd = (f_sel > `GOM_TX_IRQ);
			end else begin
				is_rsvd = 1'b0;
			end
		end
	endfunction

	// ****************************************************************
	// selection
	// ****************************************************************
	always @* begin
		rsvd_hit = is_rsvd(src, sel);
		mux_out  = 1'b0;
		if (rsvd_hit) begin
			mux_out = 1'b0;
		end else if (src[2] == 1'b0) begin
			mux_out = rx_vec[{src[1:0], sel}];
		end else if (src == `GOM_SRC_DEV) begin
			mux_out = dev_vec[sel];
		end else begin
			mux_out = tx_vec[{src[0], sel}];
		end
	end

endmodule // gom_src_mux

/* rtl/gom_pin_ctl.v */
// apb register slave and registered output driver for general-purpose pin 2
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`include "gom_defs.vh"

// Function
// - source field bits 4:2: rx ports 0-3, status, reserved, tx ports 0-1
// - rx source, select 000-011: remote pins 0-3 of that port
// - rx source, select 100-111: lock, pass, frame valid, line valid
// - status source, select 000: drive the local output value bit
// - status source, select 001: OR of lock over enabled rx ports
// - status source, select 010: AND of pass over enabled rx ports
// - status source, select 100: frame sync; 101-111 reserved
// - tx source, select 000: AND of mapped pass; 001: OR of it
// - tx source, select 010 frame valid, 011 line valid of that port
// - tx source, select 100 synchronized, 101 port interrupt, 110-111 reserved
// - bit 1 holds the level driven when the local value is selected
// - bit 0 gates the output driver: 0 off, 1 drives the source
module gom_pin_ctl (
	// clock and reset
	input  wire                   clk,
	input  wire                   reset,
	// apb slave
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [`GOM_ADDR_W-1:0] paddr,
	input  wire [31:0]            pwdata,
	output reg  [31:0]            prdata,
	output reg                    pready,
	output reg                    pslverr,
	// receive port signals
	input  wire [15:0]            rx_remote_pin,
	input  wire [3:0]             rx_lock,
	input  wire [3:0]             rx_pass,
	input  wire [3:0]             rx_frame_valid,
	input  wire [3:0]             rx_line_valid,
	input  wire [3:0]             rx_port_enable,
	// device signals
	input  wire                   frame_sync_pulse,
	// transmit port signals
	input  wire [7:0]             tx_port_map,
	input  wire [1:0]             tx_frame_valid,
	input  wire [1:0]             tx_line_valid,
	input  wire [1:0]             tx_synced,
	input  wire [1:0]             tx_irq,
	// pin
	output reg                    pin2_level,
	output reg                    pin2_oe
);

	// ****************************************************************
	// functions
	// ****************************************************************

	// OR over ports whose mask bit is set
	function any_of;
		input [3:0] f_mask;
		input [3:0] f_bits;
		begin
			any_of = |(f_mask & f_bits);
		end
	endfunction

	// AND over ports whose mask bit is set; an empty mask yields low
	// so that no enabled port never reads as a pass
	function all_of;
		input [3:0] f_mask;
		input [3:0] f_bits;
		begin
			all_of = (f_mask != 4'h0) && ((f_mask & f_bits) == f_mask);
		end
	endfunction

	// address match against a register word
	function addr_is;
		input [`GOM_ADDR_W-1:0] f_addr;
		input [`GOM_ADDR_W-1:0] f_reg;
		begin
			addr_is = (f_addr == f_reg);
		end
	endfunction

	// ****************************************************************
	// declarations
	// ****************************************************************
	// control fields
	wire [7:0]  ctl_q;
	wire [2:0]  pin2_signal_select;
	wire [2:0]  pin2_source_group;
	wire        pin2_local_level;
	wire        pin2_drive_enable;

	// apb decode
	wire        setup_phase;
	wire        access_done;
	wire        hit_ctl;
	wire        hit_stat;
	wire        ctl_wr;

	// candidates and selection
	wire        mux_out;
	wire        rsvd_hit;
	wire        any_lock;
	wire        all_pass;
	wire [1:0]  tx_and_pass;
	wire [1:0]  tx_or_pass;
	wire [31:0] rx_vec;
	wire [7:0]  dev_vec;
	wire [15:0] tx_vec;
	wire [7:0]  status_word;

	// next values
	reg  [31:0] nxt_prdata;
	reg         nxt_pslverr;
	reg         nxt_level;
	reg         nxt_oe;

	// flops
	reg         pready_ff;
	reg  [31:0] prdata_ff;
	reg         pslverr_ff;
	reg         level_ff;
	reg         oe_ff;

	// ****************************************************************
	// apb decode
	// ****************************************************************
	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready_ff;
	assign hit_ctl     = addr_is(paddr, `GOM_CTL_ADDR);
	assign hit_stat    = addr_is(paddr, `GOM_STAT_ADDR);
	// a write takes effect only at the completing edge
	assign ctl_wr      = access_done & pwrite & hit_ctl;

	// ****************************************************************
	// control register
	// ****************************************************************
	gom_ctl_store u_store (
		.clk     (clk),
		.reset   (reset),
		.wr_en   (ctl_wr),
		.wr_data (pwdata[7:0]),
		.ctl_q   (ctl_q)
	);

	assign pin2_signal_select = ctl_q[`GOM_SEL_HI:`GOM_SEL_LO];
	assign pin2_source_group  = ctl_q[`GOM_SRC_HI:`GOM_SRC_LO];
	assign pin2_local_level   = ctl_q[`GOM_VAL_BIT];
	assign pin2_drive_enable  = ctl_q[`GOM_EN_BIT];

	// ****************************************************************
	// candidate signals
	// ****************************************************************
	assign any_lock = any_of(rx_port_enable, rx_lock);
	assign all_pass = all_of(rx_port_enable, rx_pass);

	// eight candidates per rx port: remote pins, lock, pass, fv, lv
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_rx
			assign rx_vec[gi*8 +: 4]           = rx_remote_pin[gi*4 +: 4];
			assign rx_vec[gi*8 + `GOM_RX_LOCK] = rx_lock[gi];
			assign rx_vec[gi*8 + `GOM_RX_PASS] = rx_pass[gi];
			assign rx_vec[gi*8 + `GOM_RX_FV]   = rx_frame_valid[gi];
			assign rx_vec[gi*8 + `GOM_RX_LV]   = rx_line_valid[gi];
		end
	endgenerate

	// status group; slot 3 and the slots above frame sync stay low
	assign dev_vec[`GOM_DEV_LOCAL]    = pin2_local_level;
	assign dev_vec[`GOM_DEV_ANY_LOCK] = any_lock;
	assign dev_vec[`GOM_DEV_ALL_PASS] = all_pass;
	assign dev_vec[3]                 = 1'b0;
	assign dev_vec[`GOM_DEV_FSYNC]    = frame_sync_pulse;
	assign dev_vec[7:5]               = 3'h0;

	// each tx port aggregates pass over the rx ports mapped to it;
	// slots 6 and 7 are not defined and stay low
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_tx
			assign tx_and_pass[gi] = all_of(tx_port_map[gi*4 +: 4], rx_pass);
			assign tx_or_pass[gi]  = any_of(tx_port_map[gi*4 +: 4], rx_pass);
			assign tx_vec[gi*8 + `GOM_TX_PASS_AND] = tx_and_pass[gi];
			assign tx_vec[gi*8 + `GOM_TX_PASS_OR]  = tx_or_pass[gi];
			assign tx_vec[gi*8 + `GOM_TX_FV]       = tx_frame_valid[gi];
			assign tx_vec[gi*8 + `GOM_TX_LV]       = tx_line_valid[gi];
			assign tx_vec[gi*8 + `GOM_TX_SYNC]     = tx_synced[gi];
			assign tx_vec[gi*8 + `GOM_TX_IRQ]      = tx_irq[gi];
			assign tx_vec[gi*8 + 7 -: 2]           = 2'b00;
		end
	endgenerate

	// ****************************************************************
	// source selection
	// ****************************************************************
	gom_src_mux u_mux (
		.src      (pin2_source_group),
		.sel      (pin2_signal_select),
		.rx_vec   (rx_vec),
		.dev_vec  (dev_vec),
		.tx_vec   (tx_vec),
		.mux_out  (mux_out),
		.rsvd_hit (rsvd_hit)
	);

	// ****************************************************************
	// pin driver
	// ****************************************************************
	// a disabled driver also parks the level low, so nothing stale
	// shows the moment the enable is set again
	always @* begin
		nxt_level = 1'b0;
		nxt_oe    = pin2_drive_enable;
		if (pin2_drive_enable) begin
			nxt_level = mux_out;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			level_ff <= 1'b0;
		end else begin
			level_ff <= nxt_level;
		end
	end

	// enable has a flop of its own, so the pad enable never glitches
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			oe_ff <= 1'b0;
		end else begin
			oe_ff <= nxt_oe;
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	// read-only status; a write to it is dropped without an error
	assign status_word[`GOM_ST_LEVEL]    = level_ff;
	assign status_word[`GOM_ST_DRIVE]    = oe_ff;
	assign status_word[`GOM_ST_RAW]      = mux_out;
	assign status_word[`GOM_ST_RSVD]     = rsvd_hit;
	assign status_word[`GOM_ST_ANY_LOCK] = any_lock;
	assign status_word[`GOM_ST_ALL_PASS] = all_pass;
	assign status_word[7:6]              = 2'b00;

	// read data is taken in the setup cycle, so status is one cycle old
	always @* begin
		nxt_prdata  = 32'h00000000;
		nxt_pslverr = 1'b0;
		if (hit_ctl) begin
			nxt_prdata = {24'h000000, ctl_q};
		end else if (hit_stat) begin
			nxt_prdata = {24'h000000, status_word};
		end else begin
			nxt_pslverr = 1'b1;
		end
		if (pwrite) begin
			nxt_prdata = 32'h00000000;
		end
	end

	// ****************************************************************
	// apb answer
	// ****************************************************************
	// no wait state: pready rises in the first access cycle
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			pready_ff <= 1'b0;
		end else begin
			pready_ff <= setup_phase;
		end
	end

	// data and error stand only while pready does, zero otherwise
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else if (setup_phase) begin
			prdata_ff  <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end else begin
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// plain copies of flops, no logic after them
	always @* begin
		pready     = pready_ff;
		prdata     = prdata_ff;
		pslverr    = pslverr_ff;
		pin2_level = level_ff;
		pin2_oe    = oe_ff;
	end

endmodule // gom_pin_ctl

/* test/gom_pin_ctl_assertions.sv */
// assertions on the ports of the pin 2 output control block
`timescale 1ns/100ps
`include "gom_defs.vh"

module gom_pin_ctl_assertions (
	// clock and reset
	input wire                   clk,
	input wire                   reset,
	// apb
	input wire                   psel,
	input wire                   penable,
	input wire                   pwrite,
	input wire [`GOM_ADDR_W-1:0] paddr,
	input wire [31:0]            pwdata,
	input wire [31:0]            prdata,
	input wire                   pready,
	input wire                   pslverr,
	// pin
	input wire                   pin2_level,
	input wire                   pin2_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire setup  = psel && !penable;
	wire mapped = paddr == `GOM_CTL_ADDR || paddr == `GOM_STAT_ADDR;
	wire wr_ctl = psel && penable && pready && pwrite && paddr == `GOM_CTL_ADDR;

	chk_oe_write: assert property (wr_ctl |=> ##1 pin2_oe == $past(pwdata[0], 2))
		else $error("oe does not follow enable bit");
	chk_local_high: assert property (wr_ctl && pwdata[7:0] == 8'h13 |=> ##1 pin2_level)
		else $error("local level not driven");
	chk_level_gated: assert property (!pin2_oe |-> !pin2_level)
		else $error("level high while driver off");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_ready_next: assert property (setup |=> pready)
		else $error("no answer after setup");
	chk_err_unmapped: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_ok_mapped: assert property (setup && mapped |=> !pslverr)
		else $error("mapped access refused");
	chk_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("response outside access");

	cov_wr_ctl: cover property (wr_ctl);
	cov_err: cover property (pslverr);
	cov_pin_high: cover property (pin2_oe && pin2_level);
endmodule // gom_pin_ctl_assertions

bind gom_pin_ctl gom_pin_ctl_assertions u_chk (.clk(clk), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pin2_level(pin2_level), .pin2_oe(pin2_oe));

/* test/tb_gom_pin_ctl.sv */
// testbench for the pin 2 output control block
`timescale 1ns/100ps
`include "gom_defs.vh"
`define CHK(g, w) begin tests_run++; if ((g) !== (w)) begin err_count++; \
	$display("BAD %0t got %h want %h", $time, g, w); end end

module tb_gom_pin_ctl;
	// ****************
	// signals
	// ****************
	logic        clk, reset, psel, penable, pwrite, pready, pslverr;
	logic        pin2_level, pin2_oe, frame_sync_pulse, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] rx_remote_pin;
	logic [3:0]  rx_lock, rx_pass, rx_frame_valid, rx_line_valid, rx_port_enable;
	logic [7:0]  tx_port_map;
	logic [1:0]  tx_frame_valid, tx_line_valid, tx_synced, tx_irq;
	logic [2:0]  q;
	int          err_count, tests_run, s, i;

	gom_pin_ctl DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_remote_pin(rx_remote_pin), .rx_lock(rx_lock),
		.rx_pass(rx_pass), .rx_frame_valid(rx_frame_valid), .rx_line_valid(rx_line_valid),
		.rx_port_enable(rx_port_enable), .frame_sync_pulse(frame_sync_pulse),
		.tx_port_map(tx_port_map), .tx_frame_valid(tx_frame_valid),
		.tx_line_valid(tx_line_valid), .tx_synced(tx_synced), .tx_irq(tx_irq),
		.pin2_level(pin2_level), .pin2_oe(pin2_oe));

	always #5 clk = ~clk;

	// ****************
	// tasks
	// ****************
	task report_and_stop;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0) begin
				$display("All tests passed");
			end else begin
				$display("Some tests failed");
			end
			$finish;
		end
	endtask

	// entered just after a rising edge; bounded wait on pready;
	// one idle edge after release keeps two calls from overlapping
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		begin
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			k = 0;
			do begin
				@(posedge clk);
				k++;
			end while (pready !== 1'b1 && k < 16);
			if (pready !== 1'b1) begin
				err_count++;
				report_and_stop;
			end
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk);
		end
	endtask

	// write the control byte, then look at the pin once it has settled
	task mux(input logic [7:0] c, input logic x);
		begin
			apb(1'b1, `GOM_CTL_ADDR, {24'h0, c});
			repeat (2) @(posedge clk);
			`CHK(pin2_oe, c[0])
			`CHK(pin2_level, x)
		end
	endtask

	// ****************
	// sequence
	// ****************
	initial begin
		clk = 0;
		reset = 1;
		{psel, penable, pwrite, paddr, pwdata, frame_sync_pulse} = '0;
		{rx_remote_pin, rx_lock, rx_pass, rx_frame_valid, rx_line_valid} = '0;
		{rx_port_enable, tx_port_map, tx_frame_valid, tx_line_valid, tx_synced, tx_irq} = '0;
		err_count = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		`CHK(pin2_oe, 1'b0)
		apb(1'b0, `GOM_CTL_ADDR, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b1, `GOM_CTL_ADDR, 32'hA5);
		apb(1'b0, `GOM_CTL_ADDR, 32'h0);
		`CHK(rd, 32'hA5)
		apb(1'b0, 12'h04C, 32'h0);
		`CHK(er, 1'b1)
		$display("test registers done");
		// one-hot then inverted pattern catches a wrong port or signal
		for (s = 0; s < 32; s++) begin
			i = s[2:0] < 4 ? s[4:3] * 4 + s[2:0] : s[2:0] * 4 + s[4:3];
			{rx_line_valid, rx_frame_valid, rx_pass, rx_lock, rx_remote_pin} <= 32'h1 << i;
			mux({s[2:0], 1'b0, s[4:3], 2'b01}, 1'b1);
			{rx_line_valid, rx_frame_valid, rx_pass, rx_lock, rx_remote_pin} <= ~(32'h1 << i);
			mux({s[2:0], 1'b0, s[4:3], 2'b01}, 1'b0);
		end
		mux(8'h00, 1'b0);
		$display("test rx sources done");
		rx_port_enable <= 4'b0101;
		rx_lock <= 4'b1010;
		mux(8'h31, 1'b0);
		rx_lock <= 4'b0100;
		mux(8'h31, 1'b1);
		rx_pass <= 4'b1010;
		mux(8'h51, 1'b0);
		rx_pass <= 4'b0101;
		mux(8'h51, 1'b1);
		mux(8'h13, 1'b1);
		apb(1'b0, `GOM_STAT_ADDR, 32'h0);
		`CHK(rd, 32'h37)
		`CHK(er, 1'b0)
		mux(8'h11, 1'b0);
		frame_sync_pulse <= 1'b1;
		mux(8'h91, 1'b1);
		frame_sync_pulse <= 1'b0;
		mux(8'h91, 1'b0);
		$display("test device status done");
		tx_port_map <= 8'h31;
		rx_pass <= 4'b0001;
		mux(8'h19, 1'b1);
		mux(8'h1D, 1'b0);
		mux(8'h3D, 1'b1);
		rx_pass <= 4'b0000;
		mux(8'h39, 1'b0);
		for (s = 0; s < 8; s++) begin
			q = s[2:1] + 3'd2;
			{tx_irq, tx_synced, tx_line_valid, tx_frame_valid} <= 8'h1 << s;
			mux({q, 2'b11, s[0], 2'b01}, 1'b1);
			{tx_irq, tx_synced, tx_line_valid, tx_frame_valid} <= ~(8'h1 << s);
			mux({q, 2'b11, s[0], 2'b01}, 1'b0);
		end
		$display("test tx sources done");
		// every candidate high, so only a hard low passes
		{rx_line_valid, rx_frame_valid, rx_pass, rx_lock, rx_remote_pin} <= '1;
		{tx_irq, tx_synced, tx_line_valid, tx_frame_valid, frame_sync_pulse} <= '1;
		for (s = 0; s < 8; s++) begin
			mux({s[2:0], 3'b101, 2'b01}, 1'b0);
			if (s == 3 || s > 4) begin
				mux({s[2:0], 3'b100, 2'b01}, 1'b0);
			end
			if (s > 5) begin
				mux({s[2:0], 3'b110, 2'b01}, 1'b0);
				mux({s[2:0], 3'b111, 2'b01}, 1'b0);
			end
		end
		$display("test reserved codes done");
		// reset in mid-run while the driver is on
		reset <= 1'b1;
		@(posedge clk);
		`CHK(pin2_oe, 1'b0)
		reset <= 1'b0;
		apb(1'b0, `GOM_CTL_ADDR, 32'h0);
		`CHK(rd, 32'h0)
		$display("test mid-run reset done");
		report_and_stop;
	end
endmodule // tb_gom_pin_ctl
